/* File: rtl/power_reset_wake_control.sv */
// Functional notes
// - Idle bit set: enter idle when the writing instruction completes.
// - Idle gates only the processor clock; peripherals and pins keep going.
// - Enabled interrupt in idle clears idle bit and resumes execution.
// - Any reset (pin, power-on, watchdog) also ends idle.
// - Reset pin sampled at S5P2; needs two machine cycles high.
// - Reset with clock running forces PC 0000h, registers reset, no delay.
// - Power-down bit stops all clocks; ports keep their latched values.
// - Reset pin ends power-down; watchdog cannot.
// - Enabled level-mode external pin with global enable wakes power-down.
// - Reset holds while pin high, then up to two machine cycles more.
// - External pin reset sets no cause flag.
// - Watchdog time-out sets flag; with reset enabled, two-cycle reset.
// - Chip control bits 0, 1 and 7 all set cause a software reset.
// - RAM untouched; PC held 0000h during reset; stack pointer loads 07h.
// - Reset clears registers; watchdog off only on power-on; ports 0FFh.
// - Edge mode: request flag set on high-then-low machine cycle samples.
// - Edge-mode external 0 and 1 request flags cleared on vectoring.
// - Level mode: flag follows pin, not cleared on vectoring.
// - External 2 and 3 edge-mode flags are cleared only by software; level mode follows pin.
// - Serial receive and transmit flags stay until software clears them.
// - All flags software writable; per-source enables plus global enable.
// - Vectors 0003h to 003Bh in steps of eight, by source order.
`include "prwc_cfg.svh"
`default_nettype none
module power_reset_wake_control (
  input wire logic clock, // Oscillator clock, 25 MHz
  input wire logic rst, // Power-on reset, synchronous
  input wire prwc_pkg::reg_req_t bus, // Register port request
  output logic [7:0] rdata_q, // Read data, cycle after read strobe
  input wire logic rst_pin, // External reset pin, active high, async
  input wire logic [3:0] ext_irq_pins, // ext_irq0_pin..ext_irq3_pin, active low
  input wire prwc_pkg::hw_evt_t evt, // Timer and serial flag set pulses
  input wire logic wdt_timeout, // Watchdog time-out pulse
  input wire logic instr_done, // Current instruction completes
  input wire logic vector_ack, // Core performs the vector call
  output prwc_pkg::cpu_ctrl_t ctrl_q, // Core clock, reset and PC load
  output logic irq_pending_q, // An enabled request is waiting
  output logic [2:0] irq_index_q, // Source of the waiting request
  output logic [7:0] port_q, // Port latch
  output logic wdt_enable_q // Watchdog run enable
);
  import prwc_pkg::*;

  // ---------------------------------------------------------------
  // Timing and pin sampling
  // ---------------------------------------------------------------
  logic smp_stb, mc_end, fresh;
  logic [4:0] lvl, smp, fall;

  machine_cycle_timer u_mct (
    .clock(clock),
    .rst(rst),
    .smp_stb_q(smp_stb),
    .mc_end_q(mc_end)
  );

  pin_sampler u_smp (
    .clock(clock),
    .rst(rst),
    .pins({rst_pin, ext_irq_pins}),
    .smp_stb(smp_stb),
    .lvl_q(lvl),
    .smp_q(smp),
    .fall_q(fall),
    .fresh_q(fresh)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  pwr_state_t pwr_q;
  logic [7:0] pwr_reg_q, chip_q, ien_q, xctl_q, tctl_q, sctl_q, t2f_q;
  logic [7:0] stat_q, wdtc_q;
  logic [7:0] xctl_d, tctl_d, sctl_d, t2f_d;
  logic [1:0] rst_cnt_q, hold_q, hold_d;
  logic int_rst_q, rst_req, pin_rst, sw_rst, wdt_rst;
  logic [7:0] req;
  logic [2:0] idx;
  logic pd_wake, ack0, ack1, ack2, ack3;
  logic wr_pwr, wr_tctl, wr_xctl, wr_sctl;

  assign wr_pwr = bus.wr && bus.addr == `A_PWR;
  assign wr_tctl = bus.wr && bus.addr == `A_TCTL;
  assign wr_xctl = bus.wr && bus.addr == `A_XCTL;
  assign wr_sctl = bus.wr && bus.addr == `A_SCTL;

  // Vector acknowledge decoded by waiting source
  assign ack0 = vector_ack && irq_index_q == 3'h0;
  assign ack1 = vector_ack && irq_index_q == 3'h1;
  assign ack2 = vector_ack && irq_index_q == 3'h2;
  assign ack3 = vector_ack && irq_index_q == 3'h3;

  // ---------------------------------------------------------------
  // Reset sources and sequencing
  // ---------------------------------------------------------------
  // Consecutive high samples of the reset pin at S5P2
  always_ff @(posedge clock)
  begin
    if (rst)
      rst_cnt_q <= 2'h0;
    else if (fresh && !smp[4])
      rst_cnt_q <= 2'h0;
    else if (fresh && rst_cnt_q != `RST_MC_NEED)
      rst_cnt_q <= rst_cnt_q + 2'h1;
  end

  // Pin level is watched directly in power-down, where sampling has stopped
  assign pin_rst = (rst_cnt_q == `RST_MC_NEED) || (pwr_q == PWR_PDOWN && lvl[4]);
  assign sw_rst = (chip_q & `CHIP_SWRST) == `CHIP_SWRST;
  assign wdt_rst = wdt_timeout && wdtc_q[`WD_RSTEN] && wdtc_q[`WD_EN]
    && pwr_q != PWR_PDOWN;
  assign rst_req = pin_rst || sw_rst || wdt_rst;

  // Stretch reset by up to two machine cycles after its source goes away
  always_comb
  begin
    hold_d = hold_q;
    if (rst_req)
      hold_d = `HOLD_MC;
    else if (mc_end && hold_q != 2'h0)
      hold_d = hold_q - 2'h1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hold_q <= `HOLD_MC;
      int_rst_q <= 1'b1;
    end
    else
    begin
      hold_q <= hold_d;
      int_rst_q <= rst_req || hold_d != 2'h0;
    end
  end

  // Cause flags; pin reset leaves them alone, software clears by write
  always_ff @(posedge clock)
  begin
    if (rst)
      stat_q <= 8'h01;
    else
    begin
      if (bus.wr && bus.addr == `A_STAT)
        stat_q <= bus.wdata & 8'h0F;
      if (wdt_timeout)
        stat_q[`ST_WDF] <= 1'b1;
      if (wdt_rst)
        stat_q[`ST_WDR] <= 1'b1;
      if (sw_rst)
        stat_q[`ST_SWR] <= 1'b1;
    end
  end

  // Watchdog control survives every reset but power-on
  always_ff @(posedge clock)
  begin
    if (rst)
      wdtc_q <= 8'h00;
    else if (bus.wr && bus.addr == `A_WDTC)
      wdtc_q <= bus.wdata & 8'h03;
  end

  // ---------------------------------------------------------------
  // Plain control registers, cleared by any reset; port latch loads 0FFh
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst || int_rst_q)
    begin
      chip_q <= 8'h00;
      ien_q <= 8'h00;
      port_q <= `PORT_RESET;
    end
    else
    begin
      if (bus.wr && bus.addr == `A_CHIP)
        chip_q <= bus.wdata;
      if (bus.wr && bus.addr == `A_IEN)
        ien_q <= bus.wdata;
      if (bus.wr && bus.addr == `A_PORT)
        port_q <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt flags: hardware set wins over software and vectoring clears; reset clears all
  // ---------------------------------------------------------------
  always_comb
  begin
    tctl_d = wr_tctl ? bus.wdata : tctl_q;
    xctl_d = wr_xctl ? bus.wdata : xctl_q;
    sctl_d = wr_sctl ? bus.wdata : sctl_q;
    t2f_d = (bus.wr && bus.addr == `A_T2F) ? bus.wdata : t2f_q;
    // External 0 and 1: edge flags clear on vectoring, level follows pin
    if (tctl_d[`TC_IT0])
      tctl_d[`TC_IE0] = (tctl_d[`TC_IE0] && !ack0) || fall[0];
    else if (fresh)
      tctl_d[`TC_IE0] = !smp[0];
    if (tctl_d[`TC_IT1])
      tctl_d[`TC_IE1] = (tctl_d[`TC_IE1] && !ack2) || fall[1];
    else if (fresh)
      tctl_d[`TC_IE1] = !smp[1];
    // Timer 0 and 1 flags clear on vectoring
    tctl_d[`TC_TF0] = (tctl_d[`TC_TF0] && !ack1) || evt.t0_ovf;
    tctl_d[`TC_TF1] = (tctl_d[`TC_TF1] && !ack3) || evt.t1_ovf;
    // External 2 and 3: edge flags never cleared by hardware, level follows pin
    if (xctl_d[`XC_IT2])
      xctl_d[`XC_IE2] = xctl_d[`XC_IE2] || fall[2];
    else if (fresh)
      xctl_d[`XC_IE2] = !smp[2];
    if (xctl_d[`XC_IT3])
      xctl_d[`XC_IE3] = xctl_d[`XC_IE3] || fall[3];
    else if (fresh)
      xctl_d[`XC_IE3] = !smp[3];
    // Timer 2 and serial flags stay until software clears them
    t2f_d[`T2_TF] = t2f_d[`T2_TF] || evt.t2_ovf;
    t2f_d[`T2_EXF] = t2f_d[`T2_EXF] || evt.t2_cap;
    sctl_d[`SC_RX] = sctl_d[`SC_RX] || evt.ser_rx;
    sctl_d[`SC_TX] = sctl_d[`SC_TX] || evt.ser_tx;
  end

  always_ff @(posedge clock)
  begin
    if (rst || int_rst_q)
    begin
      tctl_q <= 8'h00;
      xctl_q <= 8'h00;
      sctl_q <= 8'h00;
      t2f_q <= 8'h00;
    end
    else
    begin
      tctl_q <= tctl_d;
      xctl_q <= xctl_d;
      sctl_q <= sctl_d;
      t2f_q <= t2f_d;
    end
  end

  // ---------------------------------------------------------------
  // Requests and arbitration ranking
  // ---------------------------------------------------------------
  assign req = {8{ien_q[`IEN_GLOBAL]}} & {
    xctl_q[`XC_IE3] & xctl_q[`XC_EX3],
    xctl_q[`XC_IE2] & xctl_q[`XC_EX2],
    (t2f_q[`T2_TF] | t2f_q[`T2_EXF]) & ien_q[5],
    (sctl_q[`SC_RX] | sctl_q[`SC_TX]) & ien_q[4],
    tctl_q[`TC_TF1] & ien_q[3],
    tctl_q[`TC_IE1] & ien_q[2],
    tctl_q[`TC_TF0] & ien_q[1],
    tctl_q[`TC_IE0] & ien_q[0]};

  // Lowest numbered request wins
  always_comb
  begin
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (req[i])
        idx = 3'(i);
  end

  // Reset pending or active drops any vectoring
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      irq_pending_q <= 1'b0;
      irq_index_q <= 3'h0;
    end
    else
    begin
      irq_pending_q <= |req && !rst_req && !int_rst_q
        && pwr_q != PWR_PDOWN && !vector_ack;
      irq_index_q <= idx;
    end
  end

  // ---------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------
  // Level-mode external pin held low, enabled, global enable set
  assign pd_wake = ien_q[`IEN_GLOBAL] && (
    (!tctl_q[`TC_IT0] && ien_q[0] && !lvl[0]) ||
    (!tctl_q[`TC_IT1] && ien_q[2] && !lvl[1]) ||
    (!xctl_q[`XC_IT2] && xctl_q[`XC_EX2] && !lvl[2]) ||
    (!xctl_q[`XC_IT3] && xctl_q[`XC_EX3] && !lvl[3]));

  always_ff @(posedge clock)
  begin
    if (rst)
      pwr_q <= PWR_RUN;
    else if (rst_req || int_rst_q)
      pwr_q <= PWR_RUN;
    else
    begin
      unique case (pwr_q)
        PWR_RUN:
          if (instr_done && pwr_reg_q[`PWR_PD])
            pwr_q <= PWR_PDOWN;
          else if (instr_done && pwr_reg_q[`PWR_IDLE])
            pwr_q <= PWR_IDLE;
        PWR_IDLE:
          if (|req)
            pwr_q <= PWR_RUN;
        PWR_PDOWN:
          if (pd_wake)
            pwr_q <= PWR_RUN;
      endcase
    end
  end

  // Power control register; mode bits drop as the mode ends
  always_ff @(posedge clock)
  begin
    if (rst || int_rst_q)
      pwr_reg_q <= 8'h00;
    else
    begin
      if (wr_pwr)
        pwr_reg_q <= bus.wdata;
      if (pwr_q == PWR_IDLE && |req && !rst_req)
        pwr_reg_q[`PWR_IDLE] <= 1'b0;
      if (pwr_q == PWR_PDOWN && pd_wake && !rst_req)
        pwr_reg_q[`PWR_PD] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Core controls
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_q <= '0;
      ctrl_q.cpu_reset <= 1'b1;
      ctrl_q.pc_load <= 1'b1;
      ctrl_q.sp_load <= 1'b1;
      ctrl_q.pc_value <= `PC_RESET;
      ctrl_q.sp_value <= `SP_RESET;
    end
    else
    begin
      ctrl_q.cpu_reset <= int_rst_q;
      ctrl_q.cpu_clk_en <= pwr_q == PWR_RUN;
      ctrl_q.periph_clk_en <= pwr_q != PWR_PDOWN;
      ctrl_q.osc_run <= pwr_q != PWR_PDOWN;
      ctrl_q.pc_load <= int_rst_q || vector_ack;
      ctrl_q.pc_value <= int_rst_q ? `PC_RESET
        : `VEC_BASE + {13'h0000, irq_index_q} * `VEC_STEP;
      ctrl_q.sp_load <= int_rst_q;
      ctrl_q.sp_value <= `SP_RESET;
    end
  end

  assign wdt_enable_q = wdtc_q[`WD_EN];

  // ---------------------------------------------------------------
  // Read port; unmapped offsets read zero
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst || !bus.rd)
      rdata_q <= 8'h00;
    else
    begin
      unique case (bus.addr)
        `A_PWR: rdata_q <= pwr_reg_q;
        `A_CHIP: rdata_q <= chip_q;
        `A_IEN: rdata_q <= ien_q;
        `A_XCTL: rdata_q <= xctl_q;
        `A_TCTL: rdata_q <= tctl_q;
        `A_SCTL: rdata_q <= sctl_q;
        `A_T2F: rdata_q <= t2f_q;
        `A_STAT: rdata_q <= stat_q;
        `A_WDTC: rdata_q <= wdtc_q;
        `A_PORT: rdata_q <= port_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_idle_entry: assert property (pwr_q == PWR_RUN && instr_done && pwr_reg_q[0]
    && !pwr_reg_q[1] && !rst_req && !int_rst_q |=> pwr_q == PWR_IDLE)
    else $error("idle not entered");
  a_idle_clock: assert property (pwr_q == PWR_IDLE
    |=> !ctrl_q.cpu_clk_en && ctrl_q.periph_clk_en)
    else $error("idle clock gating wrong");
  a_idle_wake: assert property (pwr_q == PWR_IDLE && |req && !rst_req
    && !int_rst_q && !bus.wr |=> pwr_q == PWR_RUN && !pwr_reg_q[0])
    else $error("idle not left on request");
  a_reset_run: assert property (rst_req |=> pwr_q == PWR_RUN && int_rst_q)
    else $error("reset did not end low power");
  a_pin_two: assert property (fresh && smp[4] && rst_cnt_q == 2'h1
    |-> ##2 int_rst_q)
    else $error("pin reset not taken");
  a_reset_tail: assert property (hold_q == 2'h1 && mc_end && !rst_req
    |=> !int_rst_q)
    else $error("reset stretch wrong");
  a_pc_zero: assert property (int_rst_q
    |=> ctrl_q.cpu_reset && ctrl_q.pc_value == 16'h0000 && ctrl_q.sp_value == 8'h07)
    else $error("reset vector wrong");
  a_sw_reset: assert property (bus.wr && bus.addr == `A_CHIP && !int_rst_q
    && (bus.wdata & 8'h83) == 8'h83 |-> ##3 ctrl_q.cpu_reset)
    else $error("software reset missed");
  a_edge_set: assert property (tctl_q[0] && fall[0] && !int_rst_q
    |=> tctl_q[1])
    else $error("edge flag not set");
  a_edge_clear: assert property (ack0 && tctl_q[0] && !fall[0] && !wr_tctl
    && !int_rst_q |=> !tctl_q[1])
    else $error("edge flag not cleared");
  a_ext23_keep: assert property (vector_ack && xctl_q[0] && xctl_q[1]
    && !wr_xctl && !int_rst_q |=> xctl_q[1])
    else $error("ext2 flag cleared by hardware");
  a_serial_hold: assert property (sctl_q[0] && !wr_sctl && !int_rst_q
    |=> sctl_q[0])
    else $error("serial flag lost");
  a_vec_addr: assert property (vector_ack && !int_rst_q
    |=> ctrl_q.pc_value == 16'h0003 + {13'h0000, $past(irq_index_q)} * 16'h0008)
    else $error("vector address wrong");

  c_idle_wake: cover property (pwr_q == PWR_IDLE ##1 pwr_q == PWR_RUN);
  c_pd_wake: cover property (pwr_q == PWR_PDOWN && pd_wake && !rst_req);
  c_sw_reset: cover property (sw_rst ##1 int_rst_q);
endmodule // power_reset_wake_control
`default_nettype wire

/* File: rtl/prwc_cfg.svh */
`ifndef PRWC_CFG_SVH
`define PRWC_CFG_SVH
// Machine cycle: 12 oscillator clocks, six states of two phases
`define MC_LAST 4'hB
// Phase count of S5P2, where pins are sampled
`define SMP_PHASE 4'h9
// Least reset pin high time in clocks, and the machine cycles it spans
`define RST_MIN_CLKS 24
`define MC_CLKS 12
`define RST_MC_NEED 2'((`RST_MIN_CLKS + `MC_CLKS - 1) / `MC_CLKS)
// Machine cycles that reset is stretched after its source goes away
`define HOLD_MC 2'h2
// Values loaded by reset
`define PC_RESET 16'h0000
`define SP_RESET 8'h07
`define PORT_RESET 8'hFF
// Vector of source n is VEC_BASE + n * VEC_STEP
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
// Register offsets
`define A_PWR 8'h00
`define A_CHIP 8'h04
`define A_IEN 8'h08
`define A_XCTL 8'h0C
`define A_TCTL 8'h10
`define A_SCTL 8'h14
`define A_T2F 8'h18
`define A_STAT 8'h1C
`define A_WDTC 8'h20
`define A_PORT 8'h24
// Field positions
`define PWR_IDLE 0
`define PWR_PD 1
`define CHIP_SWRST 8'h83
`define IEN_GLOBAL 7
`define TC_IT0 0
`define TC_IE0 1
`define TC_IT1 2
`define TC_IE1 3
`define TC_TF0 5
`define TC_TF1 7
`define XC_IT2 0
`define XC_IE2 1
`define XC_EX2 2
`define XC_IT3 4
`define XC_IE3 5
`define XC_EX3 6
`define SC_RX 0
`define SC_TX 1
`define T2_EXF 6
`define T2_TF 7
`define ST_POR 0
`define ST_WDF 1
`define ST_WDR 2
`define ST_SWR 3
`define WD_RSTEN 0
`define WD_EN 1
`endif

/* File: rtl/prwc_pkg.sv */
`default_nettype none
package prwc_pkg;
  // Power state of the processor core
  typedef enum logic [1:0] {PWR_RUN, PWR_IDLE, PWR_PDOWN} pwr_state_t;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  // Flag-setting pulses from timers and serial port
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic t2_ovf;
    logic t2_cap;
    logic ser_rx;
    logic ser_tx;
  } hw_evt_t;
  // Controls handed to the processor core
  typedef struct packed {
    logic cpu_reset;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_run;
    logic pc_load;
    logic [15:0] pc_value;
    logic sp_load;
    logic [7:0] sp_value;
  } cpu_ctrl_t;
endpackage
`default_nettype wire

/* File: rtl/machine_cycle_timer.sv */
`include "prwc_cfg.svh"
`default_nettype none
module machine_cycle_timer (
  input wire logic clock, // Oscillator clock
  input wire logic rst, // Synchronous reset
  output logic smp_stb_q, // Pulse at S5P2
  output logic mc_end_q // Pulse at end of S6P2
);
  logic [3:0] phase_q;

  // ---------------------------------------------------------------
  // Phase counter
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      phase_q <= 4'h0;
    else if (phase_q == `MC_LAST)
      phase_q <= 4'h0;
    else
      phase_q <= phase_q + 4'h1;
  end

  // Strobes one clock after the phase they mark
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      smp_stb_q <= 1'b0;
      mc_end_q <= 1'b0;
    end
    else
    begin
      smp_stb_q <= (phase_q == `SMP_PHASE);
      mc_end_q <= (phase_q == `MC_LAST);
    end
  end
endmodule // machine_cycle_timer
`default_nettype wire

/* File: rtl/pin_sampler.sv */
`default_nettype none
module pin_sampler (
  input wire logic clock, // Oscillator clock
  input wire logic rst, // Synchronous reset
  input wire logic [4:0] pins, // Asynchronous pins
  input wire logic smp_stb, // Sample strobe
  output logic [4:0] lvl_q, // Synchronised live level
  output logic [4:0] smp_q, // Level taken at the last strobe
  output logic [4:0] fall_q, // High-then-low seen at last strobe
  output logic fresh_q // New sample valid this cycle
);
  logic [4:0] meta_q;

  // ---------------------------------------------------------------
  // Per-pin synchroniser and sampler
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 5; i++)
  begin : g_pin
    always_ff @(posedge clock)
    begin
      if (rst)
      begin
        // Rest levels: interrupt pins idle high, reset pin (bit 4) idle low
        meta_q[i] <= (i < 4);
        lvl_q[i] <= (i < 4);
        smp_q[i] <= (i < 4);
        fall_q[i] <= 1'b0;
      end
      else
      begin
        meta_q[i] <= pins[i];
        lvl_q[i] <= meta_q[i];
        if (smp_stb)
          smp_q[i] <= lvl_q[i];
        fall_q[i] <= smp_stb && smp_q[i] && !lvl_q[i];
      end
    end
  end

  // Marks the cycle in which smp_q and fall_q are new
  always_ff @(posedge clock)
  begin
    if (rst)
      fresh_q <= 1'b0;
    else
      fresh_q <= smp_stb;
  end
endmodule // pin_sampler
`default_nettype wire

/* File: bench/board_partner.sv */
`default_nettype none
// -------------------------------------------------------------
// Board reset source and interrupt devices
// -------------------------------------------------------------
module board_partner (
  input wire logic clock, // Oscillator clock
  output logic rst_pin, // Reset pin, high resets
  output logic [3:0] ext_irq_pins // Interrupt pins, pulled up when idle
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins released at power-up
  initial
  begin
    rst_pin = 1'b0;
    ext_irq_pins = 4'hF;
  end

  // Holds the reset pin high for the asked number of clocks
  task automatic hold_reset(input int clks);
    rst_pin <= 1'b1;
    repeat (clks) @(posedge clock);
    rst_pin <= 1'b0;
    @(posedge clock);
  endtask

  // Sets one pin level and keeps it a full machine cycle
  task automatic drive_irq(input int idx, input logic lvl);
    ext_irq_pins[idx] <= lvl;
    repeat (12) @(posedge clock);
  endtask
endmodule // board_partner
`default_nettype wire

/* File: bench/power_reset_wake_control_tb_top.sv */
`include "prwc_cfg.svh"
`default_nettype none
module power_reset_wake_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import prwc_pkg::*;

  // -----------------------------------------------------------
  // Signals and instances
  // -----------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  reg_req_t bus = '0;
  hw_evt_t evt = '0;
  logic wdt_timeout = 1'b0;
  logic instr_done = 1'b0;
  logic vector_ack = 1'b0;
  logic rst_pin;
  logic [3:0] ext_irq_pins;
  logic [7:0] rdata_q;
  logic [7:0] port_q;
  logic irq_pending_q;
  logic wdt_enable_q;
  logic [2:0] irq_index_q;
  cpu_ctrl_t ctrl_q;
  logic [7:0] rq[$];
  logic [15:0] vq[$];
  logic rd_d = 1'b0;
  logic [7:0] d;
  int failures = 0;
  int comparisons = 0;
  int seed = 32'h4569;
  logic [7:0] fa[8] = '{`A_TCTL, `A_TCTL, `A_TCTL, `A_TCTL, `A_SCTL, `A_T2F, `A_XCTL, `A_XCTL};
  logic [7:0] fd[8] = '{8'h03, 8'h20, 8'h0C, 8'h80, 8'h01, 8'h80, 8'h07, 8'h70};
  logic [7:0] fk[8] = '{8'h01, 8'h00, 8'h04, 8'h00, 8'h01, 8'h80, 8'h07, 8'h70};

  always #20 clock = ~clock;

  power_reset_wake_control u_dut (.clock(clock), .rst(rst), .bus(bus), .rdata_q(rdata_q),
    .rst_pin(rst_pin), .ext_irq_pins(ext_irq_pins), .evt(evt), .wdt_timeout(wdt_timeout),
    .instr_done(instr_done), .vector_ack(vector_ack), .ctrl_q(ctrl_q),
    .irq_pending_q(irq_pending_q), .irq_index_q(irq_index_q), .port_q(port_q),
    .wdt_enable_q(wdt_enable_q));

  board_partner u_part (.clock(clock), .rst_pin(rst_pin), .ext_irq_pins(ext_irq_pins));

  // -----------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; a read notes its expected data
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dv);
    if (!w)
      rq.push_back(dv);
    bus <= '{a, dv, w, ~w};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
  endtask

  // Pulse: 0 timer 0 overflow, 1 instruction done, 2 vector ack, 3 time-out
  task automatic pulse(input int k);
    {wdt_timeout, vector_ack, instr_done, evt.t0_ovf} <= 4'(1 << k);
    @(posedge clock);
    {wdt_timeout, vector_ack, instr_done, evt.t0_ovf} <= 4'h0;
    @(posedge clock);
  endtask

  // Bounded wait: 0 core reset, 1 core clock enable, 2 request pending
  task automatic wait_on(input int sel, input logic v);
    int n;
    n = 0;
    while (((sel == 0) ? ctrl_q.cpu_reset : (sel == 1) ? ctrl_q.cpu_clk_en : irq_pending_q)
        !== v && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    chk(16'(n < 400), 16'h0001);
  endtask

  task automatic vec(input logic [2:0] s);
    wait_on(2, 1'b1);
    chk(16'(irq_index_q), 16'(s));
    vq.push_back(16'h0003 + 16'(s) * 16'h0008);
    pulse(2);
  endtask

  task automatic test_done;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watcher takes the oldest note as each result appears
  always @(posedge clock)
  begin
    rd_d <= bus.rd;
    if (rd_d && rq.size() > 0)
      chk(16'(rdata_q), 16'(rq.pop_front()));
    if (ctrl_q.pc_load && !ctrl_q.cpu_reset && vq.size() > 0)
      chk(ctrl_q.pc_value, vq.pop_front());
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    test_done;
  end

  // -----------------------------------------------------------
  // Tests
  // -----------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    wait_on(0, 1'b0);
    acc(0, `A_PORT, 8'hFF);
    acc(0, `A_IEN, 8'h00);
    acc(0, 8'h30, 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++)
    begin
      acc(1, `A_IEN, (i < 6) ? (8'h80 | 8'(1 << i)) : 8'h80);
      acc(1, fa[i], fd[i]);
      vec(3'(i));
      repeat (3) @(posedge clock);
      acc(0, fa[i], fk[i]);
      acc(1, fa[i], 8'h00);
    end
    $display("test vectors done");
    acc(1, `A_IEN, 8'h02);
    pulse(0);
    repeat (4) @(posedge clock);
    chk(16'(irq_pending_q), 16'h0000);
    acc(1, `A_TCTL, 8'h00);
    acc(1, `A_IEN, 8'h82);
    acc(1, `A_PWR, 8'h01);
    pulse(1);
    repeat (3) @(posedge clock);
    chk({14'h0, ctrl_q.cpu_clk_en, ctrl_q.periph_clk_en}, 16'h0001);
    pulse(0);
    wait_on(1, 1'b1);
    acc(0, `A_PWR, 8'h00);
    vec(3'd1);
    $display("test idle done");
    acc(1, `A_IEN, 8'h81);
    d = 8'($random(seed));
    acc(1, `A_PORT, d);
    acc(1, `A_PWR, 8'h02);
    pulse(1);
    repeat (3) @(posedge clock);
    chk({7'h0, ctrl_q.osc_run, port_q}, {8'h00, d});
    u_part.drive_irq(0, 1'b0);
    wait_on(1, 1'b1);
    vec(3'd0);
    acc(0, `A_TCTL, 8'h02);
    u_part.drive_irq(0, 1'b1);
    acc(1, `A_IEN, 8'h00);
    $display("test power_down done");
    acc(1, `A_TCTL, 8'h04);
    u_part.drive_irq(1, 1'b0);
    repeat (12) @(posedge clock);
    acc(0, `A_TCTL, 8'h0C);
    u_part.drive_irq(1, 1'b1);
    acc(1, `A_TCTL, 8'h00);
    $display("test edge done");
    acc(1, `A_STAT, 8'h00);
    u_part.hold_reset(6);
    repeat (30) @(posedge clock);
    chk(16'(ctrl_q.cpu_reset), 16'h0000);
    u_part.hold_reset(30);
    wait_on(0, 1'b1);
    chk(ctrl_q.pc_value, 16'h0000);
    chk(16'({ctrl_q.sp_load, ctrl_q.sp_value}), 16'h0107);
    wait_on(0, 1'b0);
    acc(0, `A_STAT, 8'h00);
    acc(0, `A_PORT, 8'hFF);
    $display("test pin_reset done");
    acc(1, `A_CHIP, 8'h83);
    wait_on(0, 1'b1);
    wait_on(0, 1'b0);
    acc(0, `A_STAT, 8'h08);
    acc(1, `A_STAT, 8'h00);
    $display("test soft_reset done");
    acc(1, `A_WDTC, 8'h03);
    pulse(3);
    wait_on(0, 1'b1);
    wait_on(0, 1'b0);
    chk(16'(wdt_enable_q), 16'h0001);
    acc(0, `A_STAT, 8'h06);
    repeat (4) @(posedge clock);
    $display("test watchdog done");
    test_done;
  end
endmodule // power_reset_wake_control_tb_top
`default_nettype wire
